// [core/lfms_seq.sv]
// Implementation choices: register access over Wishbone and the register offsets.
`include "lfms_defs.svh"

module lfms_seq #(
	parameter int unsigned TICK_CYC = `LFMS_TICK_NS / `LFMS_CLK_NS
) (
	// Clock and reset
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	// Device pins
	input  wire logic                hw_enable_pin_i,
	input  wire lfms_pkg::lfms_pins_t pins_i,
	// Wishbone slave
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [7:0]          wb_adr_i,
	input  wire logic [3:0]          wb_sel_i,
	input  wire logic [31:0]         wb_dat_i,
	output logic      [31:0]         wb_dat_o,
	output logic                     wb_ack_o,
	// Converter and sources
	output lfms_pkg::lfms_led_t      led1_o,
	output lfms_pkg::lfms_led_t      led2_o,
	output logic                     precharge_o,
	output logic                     boost_o,
	output logic                     pass_o
);
	import lfms_pkg::*;

	// ======================================================
	// Pin synchronisers
	logic       hw_enable_pin_s;
	lfms_pins_t pin_s;
	logic       strobe_prev_q;
	logic       srst;

	lfms_sync #(.W(1)) u_sync_hw_enable_pin (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   (hw_enable_pin_i),
		.q_o   (hw_enable_pin_s)
	);

	lfms_sync #(.W($bits(lfms_pins_t))) u_sync_pins (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   (pins_i),
		.q_o   (pin_s)
	);

	// Enable pin low holds every register at default
	assign srst = rst_i | ~hw_enable_pin_s;

	// ======================================================
	// Registers
	logic [7:0] enable_d, enable_q;
	logic [6:0] flash1_d, flash1_q;
	logic [6:0] flash2_d, flash2_q;
	logic [6:0] torch1_d, torch1_q;
	logic [6:0] torch2_d, torch2_q;
	logic [7:0] timing_d, timing_q;
	logic [7:0] config_d, config_q;
	logic       flag_to_d, flag_to_q;
	logic       ack_d, ack_q;
	logic [31:0] rdat_d, rdat_q;
	logic       wr_go;
	logic       rd_go;
	logic       to_hit;
	lfms_state_t st_d, st_q;

	// Bus access completes at the edge that sees ack
	assign wr_go = wb_cyc_i & wb_stb_i & wb_we_i & ack_q & wb_sel_i[0];
	assign rd_go = wb_cyc_i & wb_stb_i & ~wb_we_i & ack_q;

	// Register next values
	always_comb begin
		enable_d  = enable_q;
		flash1_d  = flash1_q;
		flash2_d  = flash2_q;
		torch1_d  = torch1_q;
		torch2_d  = torch2_q;
		timing_d  = timing_q;
		config_d  = config_q;
		flag_to_d = flag_to_q;
		if (wr_go) begin
			unique case (wb_adr_i)
				`LFMS_ADR_ENABLE: enable_d = wb_dat_i[7:0];
				`LFMS_ADR_FLASH1: flash1_d = wb_dat_i[6:0];
				`LFMS_ADR_FLASH2: flash2_d = wb_dat_i[6:0];
				`LFMS_ADR_TORCH1: torch1_d = wb_dat_i[6:0];
				`LFMS_ADR_TORCH2: torch2_d = wb_dat_i[6:0];
				`LFMS_ADR_TIMING: timing_d = wb_dat_i[7:0];
				`LFMS_ADR_CONFIG: config_d = wb_dat_i[7:0];
				default: ;
			endcase
		end
		// Reading the flag register clears it
		if (rd_go && wb_adr_i == `LFMS_ADR_FLAGS1) begin
			flag_to_d = 1'b0;
		end
		// Timeout clears the mode field and sets the flag
		if (to_hit) begin
			enable_d[`LFMS_EN_MODE_HI:`LFMS_EN_MODE_LO] =
				`LFMS_MODE_OFF;
			flag_to_d = 1'b1;
		end
	end

	// Register storage, default on reset or shutdown
	always_ff @(posedge clk_i) begin
		if (srst) begin
			enable_q  <= `LFMS_RST_ENABLE;
			flash1_q  <= `LFMS_RST_LEVEL;
			flash2_q  <= `LFMS_RST_LEVEL;
			torch1_q  <= `LFMS_RST_LEVEL;
			torch2_q  <= `LFMS_RST_LEVEL;
			timing_q  <= `LFMS_RST_TIMING;
			config_q  <= `LFMS_RST_CONFIG;
			flag_to_q <= 1'b0;
		end else begin
			enable_q  <= enable_d;
			flash1_q  <= flash1_d;
			flash2_q  <= flash2_d;
			torch1_q  <= torch1_d;
			torch2_q  <= torch2_d;
			timing_q  <= timing_d;
			config_q  <= config_d;
			flag_to_q <= flag_to_d;
		end
	end

	// ======================================================
	// Bus slave: ack one cycle after request, silent in shutdown
	always_comb begin
		ack_d  = wb_cyc_i & wb_stb_i & ~ack_q & hw_enable_pin_s;
		rdat_d = rdat_q;
		if (ack_d) begin
			unique case (wb_adr_i)
				`LFMS_ADR_ENABLE: rdat_d = {24'h0, enable_q};
				`LFMS_ADR_FLASH1: rdat_d = {25'h0, flash1_q};
				`LFMS_ADR_FLASH2: rdat_d = {25'h0, flash2_q};
				`LFMS_ADR_TORCH1: rdat_d = {25'h0, torch1_q};
				`LFMS_ADR_TORCH2: rdat_d = {25'h0, torch2_q};
				`LFMS_ADR_TIMING: rdat_d = {24'h0, timing_q};
				`LFMS_ADR_CONFIG: rdat_d = {24'h0, config_q};
				`LFMS_ADR_FLAGS1: rdat_d = {31'h0, flag_to_q};
				`LFMS_ADR_STATUS: rdat_d = {26'h0, boost_o,
					precharge_o, 1'b0, st_q};
				default:          rdat_d = 32'h0;
			endcase
		end
	end

	// Bus registers
	always_ff @(posedge clk_i) begin
		if (srst) begin
			ack_q  <= 1'b0;
			rdat_q <= 32'h0;
		end else begin
			ack_q  <= ack_d;
			rdat_q <= rdat_d;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

	// ======================================================
	// Requests decoded from mode field and pins
	logic [1:0] mode;
	logic       strobe_rise;
	logic       torch_req;
	logic       tx_act;

	assign mode        = enable_q[`LFMS_EN_MODE_HI:`LFMS_EN_MODE_LO];
	assign strobe_rise = pin_s.strobe & ~strobe_prev_q
		& enable_q[`LFMS_EN_STROBE];
	assign torch_req   = (mode == `LFMS_MODE_TORCH)
		| (pin_s.torch & enable_q[`LFMS_EN_TORCHPIN]
		& ~config_q[`LFMS_CFG_PIN_TEMP]);
	assign tx_act      = pin_s.tx & enable_q[`LFMS_EN_TX];

	// ======================================================
	// Millisecond tick and ramp step dividers
	logic [16:0] tick_d, tick_q;
	logic        ms_tick;
	logic [11:0] ramp_d, ramp_q;
	logic [11:0] ramp_per;
	logic        ramp_step;

	// Torch step period scales with the timing register rate
	assign ramp_per = (st_q == LFMS_TORCH) ?
		12'(`LFMS_RAMP_CYC) * ({9'h0, timing_q[6:4]} + 12'h001) :
		12'(`LFMS_RAMP_CYC);
	assign ms_tick   = (tick_q == 17'(TICK_CYC - 1));
	assign ramp_step = (ramp_q >= ramp_per - 12'h001);

	// Divider next values
	always_comb begin
		tick_d = ms_tick ? 17'h0 : tick_q + 17'h1;
		ramp_d = ramp_step ? 12'h0 : ramp_q + 12'h1;
	end

	// Divider registers
	always_ff @(posedge clk_i) begin
		if (srst) begin
			tick_q <= 17'h0;
			ramp_q <= 12'h0;
		end else begin
			tick_q <= tick_d;
			ramp_q <= ramp_d;
		end
	end

	// ======================================================
	// Flash timeout counter, flash and infrared only
	logic [10:0] to_cnt_d, to_cnt_q;
	logic [10:0] to_limit;
	logic        to_run;

	assign to_limit = 11'(`LFMS_TO_BASE_MS)
		+ 11'(timing_q[3:0]) * 11'(`LFMS_TO_STEP_MS);
	assign to_run   = (st_q == LFMS_FLASH)
		| (st_q == LFMS_IR && pin_s.strobe);
	assign to_hit   = to_run && to_cnt_q >= to_limit;

	// Counter next value, keeps counting through sync events
	always_comb begin
		to_cnt_d = to_cnt_q;
		if (!to_run) begin
			to_cnt_d = 11'h0;
		end else if (ms_tick && !to_hit) begin
			to_cnt_d = to_cnt_q + 11'h1;
		end
	end

	// Counter register
	always_ff @(posedge clk_i) begin
		if (srst) begin
			to_cnt_q <= 11'h0;
		end else begin
			to_cnt_q <= to_cnt_d;
		end
	end

	// ======================================================
	// Mode sequencer
	logic goal_flash_d, goal_flash_q;
	logic by_reg_d, by_reg_q;
	logic boost_d, boost_q;

	// Next state
	always_comb begin
		st_d         = st_q;
		goal_flash_d = goal_flash_q;
		by_reg_d     = by_reg_q;
		boost_d      = boost_q;
		unique case (st_q)
			LFMS_STANDBY: begin
				boost_d = 1'b0;
				if (mode == `LFMS_MODE_FLASH) begin
					st_d = LFMS_PRECHG;
					goal_flash_d = 1'b1;
					by_reg_d = 1'b1;
				end else if (strobe_rise) begin
					st_d = LFMS_PRECHG;
					goal_flash_d = 1'b1;
					by_reg_d = 1'b0;
				end else if (mode == `LFMS_MODE_IR) begin
					st_d = LFMS_IR;
				end else if (torch_req) begin
					st_d = LFMS_PRECHG;
					goal_flash_d = 1'b0;
				end
			end
			LFMS_PRECHG: begin
				// Sources stay off until output is charged
				if (goal_flash_q ? (by_reg_q ?
					mode != `LFMS_MODE_FLASH : !pin_s.strobe)
					: !torch_req) begin
					st_d = LFMS_STANDBY;
				end else if (pin_s.vout_ok) begin
					st_d = goal_flash_q ?
						LFMS_FLASH : LFMS_TORCH;
				end
			end
			LFMS_FLASH: begin
				if (to_hit) begin
					st_d = LFMS_STANDBY;
				end else if (by_reg_q ? mode != `LFMS_MODE_FLASH
					: !pin_s.strobe) begin
					st_d = LFMS_STANDBY;
				end
			end
			LFMS_TORCH: begin
				if (!torch_req || mode == `LFMS_MODE_FLASH) begin
					st_d = LFMS_STANDBY;
				end
			end
			LFMS_IR: begin
				if (to_hit || mode != `LFMS_MODE_IR) begin
					st_d = LFMS_STANDBY;
				end
			end
		endcase
		// Boost only once headroom is lost in an active ramp mode
		if ((st_q == LFMS_FLASH || st_q == LFMS_TORCH)
			&& pin_s.headroom_low) begin
			boost_d = 1'b1;
		end
	end

	// Sequencer registers
	always_ff @(posedge clk_i) begin
		if (srst) begin
			st_q          <= LFMS_STANDBY;
			goal_flash_q  <= 1'b0;
			by_reg_q      <= 1'b0;
			boost_q       <= 1'b0;
			strobe_prev_q <= 1'b0;
		end else begin
			st_q          <= st_d;
			goal_flash_q  <= goal_flash_d;
			by_reg_q      <= by_reg_d;
			boost_q       <= boost_d;
			strobe_prev_q <= pin_s.strobe;
		end
	end

	assign precharge_o = (st_q == LFMS_PRECHG);
	assign boost_o     = boost_q;
	assign pass_o      = (st_q != LFMS_STANDBY) & ~boost_q;

	// ======================================================
	// Current sources
	logic [1:0]       led_en;
	logic [1:0][6:0]  tgt;
	logic [1:0]       src_on;
	logic             ir_gate;
	lfms_led_t [1:0]  led;

	assign led_en  = {enable_q[`LFMS_EN_LED2], enable_q[`LFMS_EN_LED1]};
	assign ir_gate = (st_q == LFMS_IR) & pin_s.strobe;

	for (genvar c = 0; c < 2; c++) begin : g_src
		logic [6:0] fl;
		logic [6:0] tr;
		assign fl = c ? flash2_q : flash1_q;
		assign tr = c ? torch2_q : torch1_q;
		// Sync input swaps flash for torch level during flash
		assign tgt[c] = (st_q == LFMS_TORCH
			|| (st_q == LFMS_FLASH && tx_act)) ? tr : fl;
		assign src_on[c] = led_en[c] & (st_q == LFMS_FLASH
			|| st_q == LFMS_TORCH || ir_gate);
		lfms_ramp u_ramp (
			.clk_i     (clk_i),
			.rst_i     (srst),
			.on_i      (src_on[c]),
			.instant_i (st_q == LFMS_IR),
			.step_i    (ramp_step),
			.target_i  (tgt[c]),
			.led_o     (led[c])
		);
	end

	assign led1_o = led[0];
	assign led2_o = led[1];

	// ======================================================
	// Checks
	sequence seq_flash_req;
		st_q == LFMS_STANDBY && mode == `LFMS_MODE_FLASH;
	endsequence

	sequence seq_prechg_flash;
		st_q == LFMS_PRECHG && goal_flash_q && by_reg_q;
	endsequence

	chk_shutdown_regs: assert property (@(posedge clk_i) disable iff (rst_i)
		!hw_enable_pin_s |=> enable_q == `LFMS_RST_ENABLE && !flag_to_q)
		else $error("registers not at default in shutdown");

	chk_bus_silent: assert property (@(posedge clk_i) disable iff (rst_i)
		!hw_enable_pin_s |=> !wb_ack_o)
		else $error("bus answered in shutdown");

	chk_standby_ack: assert property (@(posedge clk_i) disable iff (rst_i)
		hw_enable_pin_s && wb_cyc_i && wb_stb_i && !ack_q ##1 hw_enable_pin_s
		|-> wb_ack_o)
		else $error("bus access not answered in one cycle");

	chk_flash_start: assert property (@(posedge clk_i) disable iff (srst)
		seq_flash_req |=> seq_prechg_flash)
		else $error("flash request did not start soft start");

	chk_timeout_clr: assert property (@(posedge clk_i) disable iff (srst)
		st_q == LFMS_FLASH && to_hit |=> mode == `LFMS_MODE_OFF
		&& flag_to_q && st_q == LFMS_STANDBY)
		else $error("timeout did not clear mode and set flag");

	chk_torch_start: assert property (@(posedge clk_i) disable iff (srst)
		st_q == LFMS_STANDBY && mode == `LFMS_MODE_TORCH
		&& !strobe_rise |=>
		st_q == LFMS_PRECHG && !goal_flash_q)
		else $error("torch request ignored");

	chk_torch_hold: assert property (@(posedge clk_i) disable iff (srst)
		st_q == LFMS_TORCH && mode == `LFMS_MODE_TORCH
		|=> st_q == LFMS_TORCH)
		else $error("torch ended while requested");

	chk_tx_torch: assert property (@(posedge clk_i) disable iff (srst)
		st_q == LFMS_FLASH && pin_s.tx |->
		tgt[0] == (enable_q[`LFMS_EN_TX] ? torch1_q : flash1_q))
		else $error("sync input target wrong");

	chk_ir_gate: assert property (@(posedge clk_i) disable iff (srst)
		st_q == LFMS_IR && !pin_s.strobe ##1 st_q == LFMS_IR
		|-> !led1_o.on && !led2_o.on)
		else $error("infrared source on without strobe");

	chk_prechg_off: assert property (@(posedge clk_i) disable iff (srst)
		st_q == LFMS_PRECHG [*2] |-> !led1_o.on && !led2_o.on)
		else $error("source on before output ready");

	chk_pass_first: assert property (@(posedge clk_i) disable iff (srst)
		$rose(precharge_o) |-> !boost_o ##1 !boost_o)
		else $error("boost active at start");

	chk_off_idle: assert property (@(posedge clk_i) disable iff (srst)
		st_q == LFMS_STANDBY |=> !led1_o.on && !led2_o.on)
		else $error("source on in standby");

endmodule

// [shared/lfms_defs.svh]
`ifndef LFMS_DEFS_SVH
`define LFMS_DEFS_SVH

// ==========================================================
// Register byte offsets
`define LFMS_ADR_ENABLE  8'h00
`define LFMS_ADR_FLASH1  8'h04
`define LFMS_ADR_FLASH2  8'h08
`define LFMS_ADR_TORCH1  8'h0C
`define LFMS_ADR_TORCH2  8'h10
`define LFMS_ADR_TIMING  8'h14
`define LFMS_ADR_CONFIG  8'h18
`define LFMS_ADR_FLAGS1  8'h1C
`define LFMS_ADR_STATUS  8'h20

// ==========================================================
// Field positions
`define LFMS_EN_MODE_LO   0
`define LFMS_EN_MODE_HI   1
`define LFMS_EN_LED1      2
`define LFMS_EN_LED2      3
`define LFMS_EN_TORCHPIN  4
`define LFMS_EN_STROBE    5
`define LFMS_EN_TX        7
`define LFMS_FLAG_TIMEOUT 0
`define LFMS_CFG_PIN_TEMP 0

// ==========================================================
// Mode field codes
`define LFMS_MODE_OFF   2'h0
`define LFMS_MODE_IR    2'h1
`define LFMS_MODE_TORCH 2'h2
`define LFMS_MODE_FLASH 2'h3

// ==========================================================
// Reset values
`define LFMS_RST_ENABLE 8'h8C
`define LFMS_RST_LEVEL  7'h00
`define LFMS_RST_TIMING 8'h0F
`define LFMS_RST_CONFIG 8'h00

// ==========================================================
// Timing
`define LFMS_CLK_NS      8
`define LFMS_TICK_NS     1000000
`define LFMS_RAMP_NS     1000
`define LFMS_RAMP_CYC    (`LFMS_RAMP_NS / `LFMS_CLK_NS)
`define LFMS_TO_BASE_MS  40
`define LFMS_TO_STEP_MS  104

`endif

// [shared/lfms_pkg.sv]
package lfms_pkg;

	// ======================================================
	// Sequencer states
	typedef enum logic [2:0] {
		LFMS_STANDBY,
		LFMS_PRECHG,
		LFMS_FLASH,
		LFMS_TORCH,
		LFMS_IR
	} lfms_state_t;

	// ======================================================
	// Asynchronous control and analog indicator pins
	typedef struct packed {
		logic strobe;
		logic torch;
		logic tx;
		logic vout_ok;
		logic headroom_low;
	} lfms_pins_t;

	// ======================================================
	// One current source command
	typedef struct packed {
		logic       on;
		logic [6:0] level;
	} lfms_led_t;

endpackage

// [core/lfms_sync.sv]
module lfms_sync #(
	parameter int unsigned W = 1
) (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// Data
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	import lfms_pkg::*;

	// ======================================================
	// Two flip-flop synchroniser per bit
	for (genvar i = 0; i < W; i++) begin : g_bit
		logic meta_q;
		logic sync_q;

		// First stage feeds only the second
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				meta_q <= 1'b0;
				sync_q <= 1'b0;
			end else begin
				meta_q <= d_i[i];
				sync_q <= meta_q;
			end
		end
		assign q_o[i] = sync_q;
	end

endmodule

// [core/lfms_ramp.sv]
module lfms_ramp (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Control
	input  wire logic       on_i,
	input  wire logic       instant_i,
	input  wire logic       step_i,
	input  wire logic [6:0] target_i,
	// Source command
	output lfms_pkg::lfms_led_t led_o
);
	import lfms_pkg::*;

	logic [6:0] level_d;
	logic [6:0] level_q;
	logic       on_d;
	logic       on_q;

	// ======================================================
	// Stepped rise to the target level; falls and instant mode go direct
	always_comb begin
		level_d = level_q;
		on_d    = on_i;
		if (!on_i) begin
			level_d = 7'h00;
		end else if (instant_i) begin
			level_d = target_i;
		end else if (level_q > target_i) begin
			level_d = target_i;
		end else if (step_i && level_q < target_i) begin
			level_d = level_q + 7'h01;
		end
	end

	// Source registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			level_q <= 7'h00;
			on_q    <= 1'b0;
		end else begin
			level_q <= level_d;
			on_q    <= on_d;
		end
	end

	assign led_o = '{on: on_q, level: level_q};

	// ======================================================
	// Checks
	chk_ramp_single: assert property (@(posedge clk_i) disable iff (rst_i)
		on_i && !instant_i && level_q < target_i |=>
		level_q <= $past(level_q) + 7'h01)
		else $error("ramp skipped a level");

	chk_ir_direct: assert property (@(posedge clk_i) disable iff (rst_i)
		on_i && instant_i |=> level_q == $past(target_i))
		else $error("instant switch did not reach target");

endmodule

// [dv/lfms_host.sv]
module lfms_host #(
	parameter int unsigned TICK_CYC = 10
) (
	// Clock
	input  wire logic        clk_i,
	// Wishbone master
	output logic             wb_cyc_o,
	output logic             wb_stb_o,
	output logic             wb_we_o,
	output logic [7:0]       wb_adr_o,
	output logic [3:0]       wb_sel_o,
	output logic [31:0]      wb_dat_o,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic        wb_ack_i
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle bus from time zero
	initial begin
		wb_cyc_o = 1'b0;
		wb_stb_o = 1'b0;
		wb_we_o  = 1'b0;
		wb_adr_o = 8'h00;
		wb_sel_o = 4'h0;
		wb_dat_o = 32'h00000000;
	end

	// Hold-off after enable rise or power-up: two device ticks plus four clocks
	task automatic power_wait();
		repeat (2 * TICK_CYC + 4) @(posedge clk_i);
	endtask

	// One classic cycle; gives up after a bounded wait for ack
	task automatic xfer(input logic we, input logic [7:0] adr,
		input logic [7:0] wdat, output logic [7:0] rdat, output logic ok);
		int n;
		ok = 1'b0;
		rdat = 8'h00;
		@(posedge clk_i);
		wb_cyc_o <= 1'b1;
		wb_stb_o <= 1'b1;
		wb_we_o  <= we;
		wb_adr_o <= adr;
		wb_sel_o <= 4'hF;
		wb_dat_o <= {24'h000000, wdat};
		for (n = 0; n < 40 && !ok; n++) begin
			@(posedge clk_i);
			if (wb_ack_i === 1'b1) begin
				ok = 1'b1;
				rdat = wb_dat_i[7:0];
			end
		end
		wb_cyc_o <= 1'b0;
		wb_stb_o <= 1'b0;
		wb_we_o  <= 1'b0;
	endtask
endmodule

// [dv/tb_top.sv]
`include "lfms_defs.svh"

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import lfms_pkg::*;

	// ==================================================
	// Signals
	logic        clk_i;
	logic        rst_i;
	logic        hw_en;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wdat;
	logic [31:0] rdat;
	logic        ack;
	logic        prech;
	logic        boost;
	logic        pass;
	lfms_pins_t  pins;
	lfms_led_t   led1;
	lfms_led_t   led2;
	int          fail_count = 0;
	int          checks = 0;
	logic        ramp_mon = 1'b1;
	logic [6:0]  lvl_prev = 7'h00;
	logic [7:0]  rv;
	logic        ok;
	int          n;
	int          t;
	int          r;
	int          f;

	// ==================================================
	// Clock, design and host
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	lfms_seq #(.TICK_CYC(10)) u_dut (
		.clk_i(clk_i), .rst_i(rst_i), .hw_enable_pin_i(hw_en),
		.pins_i(pins), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .led1_o(led1), .led2_o(led2),
		.precharge_o(prech), .boost_o(boost), .pass_o(pass));

	lfms_host #(.TICK_CYC(10)) u_host (
		.clk_i(clk_i), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we),
		.wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat),
		.wb_dat_i(rdat), .wb_ack_i(ack));

	// ==================================================
	// Helpers
	task automatic check_eq(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD t=%0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] x;
		logic       k;
		u_host.xfer(1'b1, a, d, x, k);
		check_eq(32'(k), 32'h1);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] x;
		logic       k;
		u_host.xfer(1'b0, a, 8'h00, x, k);
		check_eq(32'({k, x}), 32'({1'b1, e}));
	endtask

	task automatic wait_lvl(input logic [6:0] v, output int cnt);
		cnt = 0;
		do begin
			@(negedge clk_i);
			cnt++;
		end while (led1.level !== v && cnt < 5000);
		check_eq(32'(led1.level), 32'(v));
		// Hand back on a rising edge so pins change there
		@(posedge clk_i);
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Any rise of the source level outside infrared is one step
	always @(negedge clk_i) begin
		if (ramp_mon && led1.level > lvl_prev)
			check_eq(32'(led1.level), 32'(lvl_prev + 7'h01));
		lvl_prev = led1.level;
	end

	// Watchdog
	initial begin
		#200000;
		fail_count++;
		stop_test();
	end

	// ==================================================
	// Scenarios
	initial begin
		rst_i <= 1'b1;
		hw_en <= 1'b1;
		pins  <= '0;
		void'($urandom(23));
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		u_host.power_wait();
		// Reset values, unmapped place, full level range
		rd(`LFMS_ADR_ENABLE, 8'h8C);
		rd(`LFMS_ADR_TIMING, 8'h0F);
		rd(`LFMS_ADR_CONFIG, 8'h00);
		rd(`LFMS_ADR_FLASH2, 8'h00);
		rd(8'h3C, 8'h00);
		wr(`LFMS_ADR_FLASH1, 8'h7F);
		rd(`LFMS_ADR_FLASH1, 8'h7F);
		// Torch by register: soft start, step rate, sync, boost
		t = $urandom_range(4, 2);
		r = $urandom_range(7, 0);
		wr(`LFMS_ADR_TORCH1, 8'(t));
		wr(`LFMS_ADR_TIMING, {1'b0, 3'(r), 4'hF});
		wr(`LFMS_ADR_ENABLE, 8'h86);
		repeat (20) @(posedge clk_i);
		check_eq(32'({prech, led1.on}), 32'h2);
		rd(`LFMS_ADR_STATUS, 8'h11);
		pins.vout_ok <= 1'b1;
		wait_lvl(7'h01, n);
		wait_lvl(7'h02, n);
		check_eq(n, 125 * (r + 1));
		wait_lvl(7'(t), n);
		check_eq(32'(led2.on), 32'h0);
		pins.tx <= 1'b1;
		repeat (200) @(posedge clk_i);
		check_eq(32'(led1.level), t);
		check_eq(32'({boost, pass}), 32'h1);
		pins.headroom_low <= 1'b1;
		repeat (10) @(posedge clk_i);
		check_eq(32'({boost, pass}), 32'h2);
		pins.headroom_low <= 1'b0;
		pins.tx <= 1'b0;
		wr(`LFMS_ADR_ENABLE, 8'h84);
		repeat (10) @(posedge clk_i);
		check_eq(32'(led1.on), 32'h0);
		rd(`LFMS_ADR_STATUS, 8'h00);
		// Flash by register: sync drop and restore, then timeout
		wr(`LFMS_ADR_FLASH1, 8'h03);
		wr(`LFMS_ADR_TORCH1, 8'h01);
		wr(`LFMS_ADR_TIMING, 8'h01);
		wr(`LFMS_ADR_ENABLE, 8'h87);
		wait_lvl(7'h03, n);
		pins.tx <= 1'b1;
		repeat (20) @(posedge clk_i);
		check_eq(32'(led1.level), 32'h1);
		pins.tx <= 1'b0;
		wait_lvl(7'h03, n);
		wait_lvl(7'h00, n);
		check_eq(32'(led1.on), 32'h0);
		rd(`LFMS_ADR_ENABLE, 8'h84);
		rd(`LFMS_ADR_FLAGS1, 8'h01);
		rd(`LFMS_ADR_FLAGS1, 8'h00);
		// Flash with sync disabled keeps its level
		wr(`LFMS_ADR_ENABLE, 8'h07);
		wait_lvl(7'h03, n);
		pins.tx <= 1'b1;
		repeat (20) @(posedge clk_i);
		check_eq(32'(led1.level), 32'h3);
		pins.tx <= 1'b0;
		wait_lvl(7'h00, n);
		rd(`LFMS_ADR_FLAGS1, 8'h01);
		// Infrared: strobe level gates, no ramp, pass operation
		f = $urandom_range(100, 10);
		wr(`LFMS_ADR_FLASH1, 8'(f));
		ramp_mon = 1'b0;
		wr(`LFMS_ADR_ENABLE, 8'hA5);
		repeat (10) @(posedge clk_i);
		check_eq(32'(led1.on), 32'h0);
		pins.strobe <= 1'b1;
		repeat (8) @(posedge clk_i);
		check_eq(32'(led1), 32'({1'b1, 7'(f)}));
		check_eq(32'(pass), 32'h1);
		pins.strobe <= 1'b0;
		repeat (8) @(posedge clk_i);
		check_eq(32'(led1.on), 32'h0);
		wr(`LFMS_ADR_ENABLE, 8'h84);
		ramp_mon = 1'b1;
		// Strobe flash refused, then taken
		pins.strobe <= 1'b1;
		repeat (10) @(posedge clk_i);
		rd(`LFMS_ADR_STATUS, 8'h00);
		pins.strobe <= 1'b0;
		wr(`LFMS_ADR_ENABLE, 8'hA4);
		pins.strobe <= 1'b1;
		repeat (10) @(posedge clk_i);
		rd(`LFMS_ADR_STATUS, 8'h02);
		pins.strobe <= 1'b0;
		repeat (10) @(posedge clk_i);
		rd(`LFMS_ADR_STATUS, 8'h00);
		// Torch pin in its default use, then in temperature use
		wr(`LFMS_ADR_ENABLE, 8'h94);
		pins.torch <= 1'b1;
		repeat (10) @(posedge clk_i);
		rd(`LFMS_ADR_STATUS, 8'h03);
		wr(`LFMS_ADR_CONFIG, 8'h01);
		repeat (10) @(posedge clk_i);
		rd(`LFMS_ADR_STATUS, 8'h00);
		pins.torch <= 1'b0;
		// Shutdown: silent bus, registers back to default
		hw_en <= 1'b0;
		repeat (5) @(posedge clk_i);
		u_host.xfer(1'b0, `LFMS_ADR_ENABLE, 8'h00, rv, ok);
		check_eq(32'(ok), 32'h0);
		hw_en <= 1'b1;
		u_host.power_wait();
		rd(`LFMS_ADR_ENABLE, 8'h8C);
		rd(`LFMS_ADR_CONFIG, 8'h00);
		rd(`LFMS_ADR_FLASH1, 8'h00);
		stop_test();
	end
endmodule
